// *** hdl/cimx_top.sv ***
// Channel input selector and test signal control with APB registers
module cimx_top #(
    parameter int NUM_CH = cimx_pkg::NUM_CH
) (
    // Clock and reset
    input  wire logic                  i_mclk,
    input  wire logic                  i_rst_n,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Pins from outside the clock domain
    input  wire logic                  i_start,
    input  wire logic                  i_pace_hw_en,
    // Analog switch controls
    output logic      [4*NUM_CH-1:0]   o_route,
    output logic                       o_test_gen_en,
    output logic                       o_test_level,
    output logic                       o_test_amplitude,
    output logic                       o_drive_meas,
    output logic                       o_vref_4v,
    output logic      [3*NUM_CH-1:0]   o_gain,
    output logic      [2:0]            o_data_rate,
    // Converter timing
    output logic                       o_osc_tick,
    output logic                       o_conv_run
);
    // Register state
    logic [31:0]         cfg2;
    logic [31:0]         cfg3;
    localparam int TFREQ_W = cimx_pkg::TFREQ_SLOW_W;
    logic [6:0]          ch_set [NUM_CH];
    logic [15:0]         nco_acc;
    logic [TFREQ_W-1:0]  tdiv;
    logic [1:0]          start_sync;
    logic [1:0]          pace_sync;
    // Phase step for the 2.048 MHz tick from 125 MHz: 2048/125000 * 2^16
    localparam logic [16:0] NCO_STEP =
        17'((longint'(cimx_pkg::OSC_HZ) * 65536) / (longint'(cimx_pkg::SYS_KHZ) * 1000));

    // Bus decode
    wire         wr_en    = psel && penable && pwrite;
    wire         in_ch    = (paddr >= cimx_pkg::OFS_CH0) && (paddr < cimx_pkg::OFS_ROUTE)
                            && (paddr[1:0] == 2'h0);
    // Channel index counts from the first channel word, not from address zero
    wire  [7:0]  ch_ofs   = paddr - cimx_pkg::OFS_CH0;
    wire  [2:0]  ch_idx   = ch_ofs[4:2];
    wire         hit_cfg2 = paddr == cimx_pkg::OFS_CFG2;
    wire         hit_cfg3 = paddr == cimx_pkg::OFS_CFG3;
    wire         hit_rt   = paddr == cimx_pkg::OFS_ROUTE;
    wire         hit_st   = paddr == cimx_pkg::OFS_STATUS;
    wire         mapped   = hit_cfg2 || hit_cfg3 || hit_rt || hit_st || in_ch;
    wire  [2:0]  wr_gain  = pwdata[cimx_pkg::GAIN_LSB +: 3];
    // Illegal gain codes are refused so only seven gains exist
    wire         gain_ok  = wr_gain <= cimx_pkg::GAIN_MAX_CODE;
    wire         ch_err   = in_ch && pwrite && !gain_ok;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && (!mapped || ch_err);

    // Configuration registers; a write lands in the access phase only
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cfg2 <= cimx_pkg::CFG2_RST;
            cfg3 <= cimx_pkg::CFG3_RST;
        end
        else if (wr_en)
        begin
            if (hit_cfg2)
                cfg2 <= {21'h0, pwdata[10:0]};
            if (hit_cfg3)
                cfg3 <= {26'h0, pwdata[5:4], 4'h0};
        end
    end

    // Per-channel settings, one independent selector each
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : g_ch
            always_ff @(posedge i_mclk or negedge i_rst_n)
            begin
                if (!i_rst_n)
                    ch_set[g] <= cimx_pkg::CH_RST[6:0];
                else if (wr_en && in_ch && gain_ok && ch_idx == 3'(g))
                    ch_set[g] <= pwdata[6:0];
            end
            assign o_gain[3*g +: 3]  = ch_set[g][cimx_pkg::GAIN_LSB +: 3];
            assign o_route[4*g +: 4] = route_of(ch_set[g][2:0], cfg3[cimx_pkg::MEAS_BIT], g);
            // Each selector answers to its own field, and for code 2 also to the shared measure bit
            ch_short_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
                (ch_set[g][2:0] == 3'h1) |-> (o_route[4*g +: 4] == 4'h1))
                else $error("channel short not applied");
            ch_test_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
                (ch_set[g][2:0] == 3'h5) |-> (o_route[4*g +: 4] == 4'h6))
                else $error("channel test pair not applied");
        end
    endgenerate

    // Maps a source code to its switch setting for a channel
    // The measure bit is an argument so the decode follows every change of it
    function automatic cimx_pkg::cimx_route_t route_of(input logic [2:0] code,
                                                        input logic meas,
                                                        input int ch);
        cimx_pkg::cimx_route_t r;
        r = cimx_pkg::CIMX_RT_ELECTRODE;
        case (cimx_pkg::cimx_src_t'(code))
            cimx_pkg::CIMX_SRC_NORMAL: r = cimx_pkg::CIMX_RT_ELECTRODE;
            cimx_pkg::CIMX_SRC_SHORT:  r = cimx_pkg::CIMX_RT_MIDSUPPLY;
            // Without the measure bit the drive pin is only used as a source
            cimx_pkg::CIMX_SRC_DRIVE:  r = meas ?
                                           cimx_pkg::CIMX_RT_DRIVE_IN :
                                           cimx_pkg::CIMX_RT_OPEN;
            // Channels 3 and 4 (index 2, 3) see the digital supply quarter
            cimx_pkg::CIMX_SRC_SUPPLY: r = (ch == 2 || ch == 3) ?
                                           cimx_pkg::CIMX_RT_DIG_SUP :
                                           cimx_pkg::CIMX_RT_ANA_SUP;
            cimx_pkg::CIMX_SRC_TEMP:   r = cimx_pkg::CIMX_RT_TEMP;
            // Aux pair reaches any channel; pace must not be using it
            cimx_pkg::CIMX_SRC_TEST:   r = cimx_pkg::CIMX_RT_TEST;
            default:                   r = cimx_pkg::CIMX_RT_RESERVED;
        endcase
        return r;
    endfunction

    // Pin synchronisers; first stage feeds only the second
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            start_sync <= 2'h0;
            pace_sync  <= 2'h0;
        end
        else
        begin
            start_sync <= {start_sync[0], i_start};
            pace_sync  <= {pace_sync[0], i_pace_hw_en};
        end
    end
    assign o_conv_run = start_sync[1];

    // Phase accumulator makes the 2.048 MHz converter tick from the core clock
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            nco_acc <= 16'h0000;
        else
            nco_acc <= nco_acc + NCO_STEP[15:0];
    end
    wire [16:0] nco_sum = {1'b0, nco_acc} + NCO_STEP;
    assign o_osc_tick = nco_sum[16];

    // Test square wave divider runs on the tick; cleared to zero while generator is off
    wire test_int = cfg2[cimx_pkg::TEST_INT_BIT];
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            tdiv <= '0;
        else if (!test_int)
            tdiv <= '0;
        else if (o_osc_tick)
            tdiv <= tdiv + 1'b1;
    end
    wire [1:0] tfreq = cfg2[cimx_pkg::TEST_FREQUENCY_LSB +: 2];
    // Freq code 11 is a DC level, 00 slow, 01 fast
    assign o_test_level = (tfreq == 2'h3) ? 1'b1 :
                          (tfreq == 2'h1) ? tdiv[TFREQ_W-2] : tdiv[TFREQ_W-1];
    assign o_test_amplitude    = cfg2[cimx_pkg::TEST_AMPLITUDE_BIT];
    assign o_test_gen_en = test_int;
    assign o_drive_meas  = cfg3[cimx_pkg::MEAS_BIT];
    assign o_vref_4v     = cfg3[cimx_pkg::VREF4_BIT];
    assign o_data_rate   = cfg2[cimx_pkg::DR_LSB +: 3];

    // Read mux; status shows pace pin and the pace/test clash
    wire clash = pace_sync[1] && test_int;
    wire [31:0] rd_ch = {25'h0, ch_set[ch_idx]};
    wire [31:0] rd_val = hit_cfg2 ? cfg2 :
                         hit_cfg3 ? cfg3 :
                         hit_rt   ? {{(32-4*NUM_CH){1'b0}}, o_route} :
                         hit_st   ? {29'h0, clash, pace_sync[1], start_sync[1]} :
                         in_ch    ? rd_ch : 32'h0000_0000;
    assign prdata = (psel && !pwrite) ? rd_val : 32'h0000_0000;

    // Reset routing of channel 1: default setting code 1 shorts inputs
    sel_short_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (ch_set[0][2:0] == 3'h1) |-> (o_route[3:0] == 4'h1))
        else $error("short code not routed to mid-supply");
    test_route_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (ch_set[1][2:0] == 3'h5) |-> (o_route[7:4] == 4'h6))
        else $error("test code not routed to test pair");
    sup_dig_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (ch_set[2][2:0] == 3'h3) |-> (o_route[11:8] == 4'h4))
        else $error("channel 3 supply not digital");
    drv_meas_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (ch_set[0][2:0] == 3'h2 && cfg3[4]) |-> (o_route[3:0] == 4'h2))
        else $error("drive input not measured");
    test_off_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !test_int |=> (tdiv == '0))
        else $error("test divider ran while disabled");
    gain_legal_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        ch_set[0][6:4] <= 3'h6)
        else $error("illegal gain stored");
    ch_write_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (wr_en && in_ch && gain_ok && ch_idx == 3'h0) |=> (ch_set[0] == $past(pwdata[6:0])))
        else $error("channel setting not stored");
    tick_rate_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_osc_tick |=> !o_osc_tick)
        else $error("tick longer than one cycle");
    // Start pin rises and then stays up for the two synchroniser stages
    sequence s_start_held;
        $rose(i_start) ##1 i_start[*2];
    endsequence
    start_sync_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        s_start_held |-> o_conv_run)
        else $error("start not passed within two cycles");
    // A configuration write seen in its access phase
    sequence s_cfg2_wr;
        wr_en && hit_cfg2;
    endsequence
    sequence s_cfg3_wr;
        wr_en && hit_cfg3;
    endsequence
    // Refused channel write leaves the stored setting alone
    bad_gain_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (wr_en && in_ch && !gain_ok && ch_idx == 3'h0) |=> $stable(ch_set[0]))
        else $error("illegal gain write changed setting");
    gain_err_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (wr_en && in_ch && !gain_ok) |-> pslverr)
        else $error("illegal gain write not refused");
    rate_wr_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        s_cfg2_wr |=> (o_data_rate == $past(pwdata[10:8])))
        else $error("data rate not taken");
    test_en_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        s_cfg2_wr |=> (o_test_gen_en == $past(pwdata[4])))
        else $error("test source bit not taken");
    amp_wr_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        s_cfg2_wr |=> (o_test_amplitude == $past(pwdata[2])))
        else $error("test amplitude not taken");
    vref_wr_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        s_cfg3_wr |=> (o_vref_4v == $past(pwdata[5])))
        else $error("reference select not taken");
    meas_wr_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        s_cfg3_wr |=> (o_drive_meas == $past(pwdata[4])))
        else $error("measure bit not taken");
    // Code 11 holds the test output high instead of toggling
    dc_level_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (tfreq == 2'h3) |-> o_test_level)
        else $error("dc test level not high");
    drv_open_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (ch_set[0][2:0] == 3'h2 && !cfg3[4]) |-> (o_route[3:0] == 4'h8))
        else $error("drive code without measure not open");
    sup_ana_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (ch_set[0][2:0] == 3'h3) |-> (o_route[3:0] == 4'h3))
        else $error("channel 1 supply not analog");
    sup_dig4_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (ch_set[3][2:0] == 3'h3) |-> (o_route[15:12] == 4'h4))
        else $error("channel 4 supply not digital");
    aux_any_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (ch_set[7][2:0] == 3'h5) |-> (o_route[31:28] == 4'h6))
        else $error("aux pair not on last channel");
    // The tick is far slower than the core clock, so a gap always follows it
    tick_gap_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_osc_tick |=> !o_osc_tick [*8])
        else $error("ticks too close together");
    unmapped_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (psel && penable && !mapped) |-> pslverr)
        else $error("unmapped access not refused");
    rd_idle_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !psel |-> (prdata == 32'h0000_0000))
        else $error("read data driven while idle");
    res_route_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (ch_set[0][2:0] == 3'h6) |-> (o_route[3:0] == 4'h7))
        else $error("reserved code not flagged");
endmodule

// *** hdl/cimx_pkg.sv ***
// Constants, types and register map of the channel input selection block
// Operation
// - Eight selectors, each steered by own field
// - Code 001 shorts inputs to mid-supply
// - Code 101 routes internal test pair
// - Code 011 applies channel-dependent supply monitor
// - Code 010 with measure bit reads drive input
// - Test-source bit low disables internal generator
// - Amplitude and frequency fields set test signal
// - Gain is one of seven values
// - Data rate selectable 250 to 32k
// - Internal oscillator gives 2.048 MHz tick
// - Reference selectable 2.4 V or 4 V
// - Aux differential pair routable to any channel
// - Common start pin synchronises conversions
package cimx_pkg;
    localparam int          NUM_CH         = 8;
    // Register byte offsets
    localparam logic [7:0]  OFS_CFG2       = 8'h00;
    localparam logic [7:0]  OFS_CFG3       = 8'h04;
    localparam logic [7:0]  OFS_CH0        = 8'h10;
    localparam logic [7:0]  OFS_ROUTE      = 8'h30;
    localparam logic [7:0]  OFS_STATUS     = 8'h34;
    // Field positions in config_two
    localparam int          TEST_INT_BIT   = 4;
    localparam int          TEST_AMPLITUDE_BIT   = 2;
    localparam int          TEST_FREQUENCY_LSB  = 0;
    localparam int          DR_LSB         = 8;
    // Field positions in config_three
    localparam int          MEAS_BIT       = 4;
    localparam int          VREF4_BIT      = 5;
    // Field positions in channel_setting
    localparam int          GAIN_LSB       = 4;
    // Reset values
    localparam logic [31:0] CFG2_RST       = 32'h0000_0000;
    localparam logic [31:0] CFG3_RST       = 32'h0000_0000;
    localparam logic [31:0] CH_RST         = 32'h0000_0061;
    // Clock figures: the core runs at 125 MHz, the converter tick at 2.048 MHz
    localparam int          SYS_KHZ        = 125000;
    localparam int          OSC_HZ         = 2048000;
    // Test signal toggles every 2^20 ticks (freq 00) or 2^19 ticks (freq 01)
    localparam int          TFREQ_SLOW_W   = 21;
    // Source codes
    typedef enum logic [2:0] {
        CIMX_SRC_NORMAL = 3'h0,
        CIMX_SRC_SHORT  = 3'h1,
        CIMX_SRC_DRIVE  = 3'h2,
        CIMX_SRC_SUPPLY = 3'h3,
        CIMX_SRC_TEMP   = 3'h4,
        CIMX_SRC_TEST   = 3'h5,
        CIMX_SRC_RES6   = 3'h6,
        CIMX_SRC_RES7   = 3'h7
    } cimx_src_t;
    // Routing outcome per channel, one-hot-free code
    typedef enum logic [3:0] {
        CIMX_RT_ELECTRODE = 4'h0,
        CIMX_RT_MIDSUPPLY = 4'h1,
        CIMX_RT_DRIVE_IN  = 4'h2,
        CIMX_RT_ANA_SUP   = 4'h3,
        CIMX_RT_DIG_SUP   = 4'h4,
        CIMX_RT_TEMP      = 4'h5,
        CIMX_RT_TEST      = 4'h6,
        CIMX_RT_RESERVED  = 4'h7,
        CIMX_RT_OPEN      = 4'h8
    } cimx_route_t;
    // Gain codes 0..6 stand for 6,1,2,3,4,8,12; code 7 is refused
    localparam logic [2:0]  GAIN_MAX_CODE  = 3'h6;
endpackage

// *** tb/cimx_host.sv ***
// Host-side APB master model that configures the channel selector
module cimx_host (
    // Bus clock
    input  wire logic        i_mclk,
    // Request side
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    // Answer side
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus from time zero
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end
    // One transfer; the request holds until pready is seen high, so slow slaves work too
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge i_mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_mclk);
        penable <= 1'b1;
        do @(posedge i_mclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// *** tb/channel_input_mux_control_tb_top.sv ***
// Self-checking bench for the channel input selector
module channel_input_mux_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_mclk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic        i_start = 1'b0;
    logic        i_pace_hw_en = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [31:0] o_route;
    logic [23:0] o_gain;
    logic [2:0]  o_data_rate;
    logic        o_test_gen_en, o_test_level, o_test_amplitude, o_drive_meas;
    logic        o_vref_4v, o_osc_tick, o_conv_run;
    int          err_total = 0;
    int          check_count = 0;
    int          cyc = 0;
    // Clock, 8 ns period
    always #4 i_mclk = ~i_mclk;
    cimx_host host (.i_mclk(i_mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    cimx_top DUT (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .i_start(i_start), .i_pace_hw_en(i_pace_hw_en), .o_route(o_route),
        .o_test_gen_en(o_test_gen_en), .o_test_level(o_test_level), .o_test_amplitude(o_test_amplitude),
        .o_drive_meas(o_drive_meas), .o_vref_4v(o_vref_4v), .o_gain(o_gain),
        .o_data_rate(o_data_rate), .o_osc_tick(o_osc_tick), .o_conv_run(o_conv_run));
    // Compare one value
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Access with expected error flag; settle a moment so registered outputs land
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic xe);
        host.xfer(w, a, d, q, e);
        #1;
        chk({31'h0, e}, {31'h0, xe});
    endtask
    // Expected switch setting of a channel
    function automatic logic [3:0] rt(input int ch, input logic [2:0] c, input logic m);
        case (c)
            3'h1: rt = 4'h1;
            3'h2: rt = m ? 4'h2 : 4'h8;
            3'h3: rt = (ch == 2 || ch == 3) ? 4'h4 : 4'h3;
            3'h4: rt = 4'h5;
            3'h5: rt = 4'h6;
            3'h6, 3'h7: rt = 4'h7;
            default: rt = 4'h0;
        endcase
    endfunction
    // Reset state: every channel shorted to mid-supply
    task automatic t_reset();
        for (int ch = 0; ch < 8; ch++)
        begin
            acc(1'b0, 8'h10 + 8'(4 * ch), 32'h0, 1'b0);
            chk(q, 32'h0000_0061);
        end
        chk(o_route, {8{4'h1}});
        acc(1'b0, 8'h30, 32'h0, 1'b0);
        chk(q, 32'h1111_1111);
    endtask
    // Every code on every channel, each channel on its own code; gain kept at one
    task automatic t_codes(input logic m);
        acc(1'b1, 8'h04, {27'h0, m, 4'h0}, 1'b0);
        chk({31'h0, o_drive_meas}, {31'h0, m});
        for (int c = 0; c < 8; c++)
        begin
            for (int ch = 0; ch < 8; ch++)
                acc(1'b1, 8'h10 + 8'(4 * ch), 32'h10 | 32'((ch + c) % 8), 1'b0);
            for (int ch = 0; ch < 8; ch++)
                chk(32'(o_route[4*ch+:4]), 32'(rt(ch, 3'((ch + c) % 8), m)));
        end
    endtask
    // Test generator, amplitude, frequency, rate and reference fields
    task automatic t_cfg();
        acc(1'b1, 8'h00, 32'h0000_0517, 1'b0);
        chk({o_test_gen_en, o_test_amplitude, o_test_level}, 3'h7);
        chk(32'(o_data_rate), 32'h5);
        acc(1'b1, 8'h00, 32'h0000_0000, 1'b0);
        chk({o_test_gen_en, o_test_amplitude}, 2'h0);
        acc(1'b1, 8'h04, 32'h0000_0020, 1'b0);
        chk(32'(o_vref_4v), 32'h1);
    endtask
    // Seven legal gains stored, the eighth code and an unmapped address refused
    task automatic t_gain();
        for (int g = 0; g < 8; g++)
        begin
            acc(1'b1, 8'h10, 32'(g << 4) | 32'h1, g == 7);
            acc(1'b0, 8'h10, 32'h0, 1'b0);
            chk(q, g == 7 ? 32'h61 : 32'(g << 4) | 32'h1);
            chk(32'(o_gain[2:0]), g == 7 ? 32'h6 : 32'(g));
        end
        acc(1'b0, 8'h40, 32'h0, 1'b1);
        chk(q, 32'h0);
    endtask
    // Oscillator tick rate and synchronised start
    task automatic t_timing();
        int n;
        n = 0;
        repeat (1000) @(posedge i_mclk) n += int'(o_osc_tick === 1'b1);
        chk(32'(n >= 16 && n <= 17), 32'h1);
        i_start <= 1'b1;
        repeat (6) @(posedge i_mclk);
        chk(32'(o_conv_run), 32'h1);
        acc(1'b0, 8'h34, 32'h0, 1'b0);
        chk(q, 32'h1);
        @(posedge i_mclk);
        i_pace_hw_en <= 1'b1;
        acc(1'b1, 8'h00, 32'h0000_0010, 1'b0);
        acc(1'b0, 8'h34, 32'h0, 1'b0);
        chk(q, 32'h7);
    endtask
    // Verdict
    task automatic end_of_test();
        $display("Checks %0d, errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Hang guard
    always @(posedge i_mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            end_of_test();
        end
    end
    // Main sequence
    initial
    begin
        repeat (12) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        t_reset();
        t_codes(1'b0);
        t_codes(1'b1);
        t_cfg();
        t_gain();
        t_timing();
        end_of_test();
    end
endmodule
